/* File: design/lvtx_pkg.sv */
// Package for the serial transmitter: register map, field layout, reset values,
// output modes and the packed carriers shared by the transmitter files.
// Assumes a 32-bit APB slave with byte addresses and one register per word.
package lvtx_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h0_000;
  localparam logic [11:0] OFS_FACTOR  = 12'h0_004;
  localparam logic [11:0] OFS_FWDDIV  = 12'h0_008;
  localparam logic [11:0] OFS_PREEMPH = 12'h0_00C;
  localparam logic [11:0] OFS_STATUS  = 12'h0_010;
  localparam logic [11:0] OFS_WORDCNT = 12'h0_014;

  // Control register fields
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_MODE_LSB   = 1;
  localparam int CTRL_CLKCH_BIT  = 3;
  localparam int CTRL_FWDEN_BIT  = 4;
  localparam int CTRL_PHASE_BIT  = 5;

  // Pre-emphasis register fields
  localparam int PRE_LVL_LSB     = 0;
  localparam int PRE_VARIANT_BIT = 4;

  // Status register fields
  localparam int STAT_RUN_BIT    = 0;
  localparam int STAT_CNT_LSB    = 4;
  localparam int STAT_FAC_LSB    = 8;

  // Widths and limits
  localparam int WORD_W          = 10;
  localparam logic [3:0] MAX_FACTOR = 4'h0_00A;

  // Reset values, pre-emphasis limit and idle level
  localparam logic [3:0] RST_FACTOR   = 4'h0_00A;
  localparam logic [3:0] RST_FWDDIV   = 4'h0_001;
  localparam logic [1:0] RST_PRE_VAR0 = 2'h0_001;
  localparam logic [1:0] RST_PRE_VAR1 = 2'h0_000;
  localparam logic [1:0] PRE_MAX_VAR0 = 2'h0_001;
  localparam logic       IDLE_LEVEL   = 1'h0_000;

  // Output path modes
  typedef enum logic [1:0] {
    MODE_SER = 2'b00,
    MODE_DDR = 2'b01,
    MODE_SDR = 2'b10
  } lvtx_mode_t;

  // Static configuration as held by the register file
  typedef struct packed {
    logic       enable;
    lvtx_mode_t mode;
    logic       clk_chan;
    logic       fwd_en;
    logic       phase_180;
    logic [3:0] factor;
    logic [3:0] fwd_div;
    logic       pre_variant;
    logic [1:0] pre_level;
  } lvtx_cfg_t;

  // Two bits for one clock period: first half, second half
  typedef struct packed {
    logic first;
    logic second;
  } lvtx_pair_t;

endpackage

/* File: design/lvtx_out_elem.sv */
// Output element: two data output registers that serve serial and DDR; SDR bypasses them.
// Assumes the pin driver merges the two halves on the two clock phases.
`timescale 1ns/1ps
module lvtx_out_elem (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire lvtx_pkg::lvtx_mode_t mode,
  input  wire lvtx_pkg::lvtx_pair_t din,
  output logic                     out_first,
  output logic                     out_second
);

  // State: the two output registers
  typedef struct packed {
    logic reg_a_ff;
    logic reg_b_ff;
  } lvtx_oe_state_t;

  lvtx_oe_state_t st_ff;
  lvtx_oe_state_t nxt_st;

  // Both registers capture on every rising edge, in any mode
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.reg_a_ff = din.first;
    nxt_st.reg_b_ff = din.second;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // SDR bypasses the registers, the others use them
  always_comb begin
    if (mode == lvtx_pkg::MODE_SDR) begin
      out_first  = din.first;
      out_second = din.first;
    end else begin
      out_first  = st_ff.reg_a_ff;
      out_second = st_ff.reg_b_ff;
    end
  end

endmodule

/* File: design/lvtx_top.sv */
// Serial transmitter datapath with APB register file and forwarded clock.
// Assumes CLK is the serial bit clock and TX_WORD comes from logic on CLK.
//
// Contract
// - Each word leaves most significant bit first, then the rest in descending order.
// - Parallel load and shift registers run on the bit clock; a load strobe picks capture.
// - The serialization factor is static and only 4, 6, 7, 8 or 10 is accepted.
// - The load strobe comes from the factor, one word per factor bit periods.
// - Bypass runs DDR with two bits per clock or SDR with one bit per clock.
// - The output element has two output registers, used for serial and DDR; SDR bypasses them.
// - Bypass DDR registers the output on the clock; bypass SDR passes data straight.
// - The parallel input is up to 10 bits wide and its used width equals the factor.
// - A forwarded clock divides by 1, 2, 4, 6, 8 or 10, as the factor allows.
// - The forwarded clock phase is statically 0 or 180 degrees against the data.
// - In clock output mode the data channel sends a clock through the serializer.
// - Pre-emphasis is static: 0 or 1 (default 1) on one variant, 0 to 3 (default 0) on the other.
`timescale 1ns/1ps
module lvtx_top (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [9:0]  TX_WORD,
  output logic             TX_LOAD,
  output logic             TX_OUT_FIRST,
  output logic             TX_OUT_SECOND,
  output logic             TX_FWD_FIRST,
  output logic             TX_FWD_SECOND,
  output logic [1:0]       TX_PREEMPH
);

  // All state of the transmitter except the reset synchronizer and the output element registers
  typedef struct packed {
    lvtx_pkg::lvtx_cfg_t cfg_ff;
    logic [31:0]         prdata_ff;
    logic                slverr_ff;
    logic [3:0]          bit_cnt_ff;
    logic [9:0]          par_ff;
    logic                par_vld_ff;
    logic [9:0]          shift_ff;
    logic                shift_vld_ff;
    logic [3:0]          fwd_cnt_ff;
    logic                ser_bit_ff;
    logic                fwd_a_ff;
    logic                fwd_b_ff;
    logic [15:0]         word_cnt_ff;
  } lvtx_state_t;

  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  lvtx_state_t st_ff;
  lvtx_state_t nxt_st;
  logic        load_stb;
  logic        shift_load;
  logic        wr_en;
  logic        rd_en;
  logic [9:0]  word_in;
  logic [3:0]  nxt_fwd;
  lvtx_pkg::lvtx_pair_t data_pair;
  lvtx_pkg::lvtx_pair_t fwd_pair;

  // Accepted serialization factors
  function automatic logic legal_factor(input logic [3:0] f);
    case (f)
      4'h0_004, 4'h0_006, 4'h0_007, 4'h0_008, 4'h0_00A: legal_factor = 1'b1;
      default: legal_factor = 1'b0;
    endcase
  endfunction

  // Forwarded clock divides that fit a whole number of times in a word
  function automatic logic legal_div(input logic [3:0] f, input logic [3:0] d);
    case (d)
      4'h0_001: legal_div = 1'b1;
      4'h0_002: legal_div = (f == 4'h0_004) || (f == 4'h0_006) || (f == 4'h0_008) ||
                            (f == 4'h0_00A);
      4'h0_004: legal_div = (f == 4'h0_004) || (f == 4'h0_008);
      4'h0_006: legal_div = (f == 4'h0_006);
      4'h0_008: legal_div = (f == 4'h0_008);
      4'h0_00A: legal_div = (f == 4'h0_00A);
      default:  legal_div = 1'b0;
    endcase
  endfunction

  // Clock pattern word: upper half of the factor high, rest low
  function automatic logic [9:0] clk_pattern(input logic [3:0] f);
    logic [9:0] pat;
    pat = '0;
    for (int i = 0; i < lvtx_pkg::WORD_W; i++) begin
      if ((i < 32'(f)) && (i >= 32'(f) / 2)) begin
        pat[i] = 1'b1;
      end
    end
    clk_pattern = pat;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_ff <= 2'h0_000;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // APB decode, zero wait states
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && !PENABLE && !PWRITE;
  assign PREADY  = 1'b1;
  assign PRDATA  = st_ff.prdata_ff;
  assign PSLVERR = st_ff.slverr_ff && PSEL && PENABLE;

  // Word source: user data or clock pattern
  assign word_in = st_ff.cfg_ff.clk_chan ? clk_pattern(st_ff.cfg_ff.factor)
                                         : TX_WORD;

  // Strobe at the last bit period of each word; every clock in bypass
  assign load_stb   = st_ff.cfg_ff.enable &&
                      ((st_ff.cfg_ff.mode != lvtx_pkg::MODE_SER) ||
                       (st_ff.bit_cnt_ff == st_ff.cfg_ff.factor - 4'h0_001));
  assign shift_load = st_ff.cfg_ff.enable && (st_ff.bit_cnt_ff == 4'h0_000);
  assign TX_LOAD    = load_stb;

  // Forwarded clock counter value after this edge
  assign nxt_fwd = (shift_load || st_ff.fwd_cnt_ff == st_ff.cfg_ff.fwd_div - 4'h0_001)
                 ? 4'h0_000 : st_ff.fwd_cnt_ff + 4'h0_001;

  // Next state: registers, serializer and forwarded clock
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.slverr_ff = 1'b0;
    // Read data captured in the setup phase
    if (rd_en) begin
      nxt_st.prdata_ff = '0;
      case (PADDR)
        lvtx_pkg::OFS_CTRL: begin
          nxt_st.prdata_ff[lvtx_pkg::CTRL_EN_BIT]    = st_ff.cfg_ff.enable;
          nxt_st.prdata_ff[lvtx_pkg::CTRL_MODE_LSB +: 2] = st_ff.cfg_ff.mode;
          nxt_st.prdata_ff[lvtx_pkg::CTRL_CLKCH_BIT] = st_ff.cfg_ff.clk_chan;
          nxt_st.prdata_ff[lvtx_pkg::CTRL_FWDEN_BIT] = st_ff.cfg_ff.fwd_en;
          nxt_st.prdata_ff[lvtx_pkg::CTRL_PHASE_BIT] = st_ff.cfg_ff.phase_180;
        end
        lvtx_pkg::OFS_FACTOR: nxt_st.prdata_ff[3:0] = st_ff.cfg_ff.factor;
        lvtx_pkg::OFS_FWDDIV: nxt_st.prdata_ff[3:0] = st_ff.cfg_ff.fwd_div;
        lvtx_pkg::OFS_PREEMPH: begin
          nxt_st.prdata_ff[lvtx_pkg::PRE_LVL_LSB +: 2]  = st_ff.cfg_ff.pre_level;
          nxt_st.prdata_ff[lvtx_pkg::PRE_VARIANT_BIT]   = st_ff.cfg_ff.pre_variant;
        end
        lvtx_pkg::OFS_STATUS: begin
          nxt_st.prdata_ff[lvtx_pkg::STAT_RUN_BIT]      = st_ff.shift_vld_ff;
          nxt_st.prdata_ff[lvtx_pkg::STAT_CNT_LSB +: 4] = st_ff.bit_cnt_ff;
          nxt_st.prdata_ff[lvtx_pkg::STAT_FAC_LSB +: 4] = st_ff.cfg_ff.factor;
        end
        lvtx_pkg::OFS_WORDCNT: nxt_st.prdata_ff[15:0] = st_ff.word_cnt_ff;
        default: nxt_st.slverr_ff = 1'b1;
      endcase
    end else if (PSEL && !PENABLE) begin
      case (PADDR)
        lvtx_pkg::OFS_CTRL, lvtx_pkg::OFS_FACTOR, lvtx_pkg::OFS_FWDDIV,
        lvtx_pkg::OFS_PREEMPH, lvtx_pkg::OFS_STATUS, lvtx_pkg::OFS_WORDCNT:
          nxt_st.slverr_ff = 1'b0;
        default: nxt_st.slverr_ff = 1'b1;
      endcase
    end else if (PSEL && PENABLE) begin
      nxt_st.slverr_ff = st_ff.slverr_ff;
    end

    // Serializer: counter, parallel load register, shift register
    if (!st_ff.cfg_ff.enable) begin
      nxt_st.bit_cnt_ff   = '0;
      nxt_st.par_vld_ff   = 1'b0;
      nxt_st.shift_vld_ff = 1'b0;
      nxt_st.fwd_cnt_ff   = '0;
    end else if (st_ff.cfg_ff.mode == lvtx_pkg::MODE_SER) begin
      nxt_st.bit_cnt_ff = load_stb ? 4'h0_000 : st_ff.bit_cnt_ff + 4'h0_001;
      if (load_stb) begin
        nxt_st.par_ff      = word_in;
        nxt_st.par_vld_ff  = 1'b1;
        nxt_st.word_cnt_ff = st_ff.word_cnt_ff + 16'h0_001;
      end
      if (shift_load) begin
        // Left align so the top bit of the word leaves first
        nxt_st.shift_ff     = 10'(st_ff.par_ff << (lvtx_pkg::MAX_FACTOR -
                                                   st_ff.cfg_ff.factor));
        nxt_st.shift_vld_ff = st_ff.par_vld_ff;
      end else begin
        nxt_st.shift_ff = {st_ff.shift_ff[8:0], 1'b0};
      end
      nxt_st.fwd_cnt_ff = nxt_fwd;
    end else begin
      // Bypass: the fabric word goes straight to the output element
      nxt_st.bit_cnt_ff   = '0;
      nxt_st.shift_vld_ff = 1'b1;
      nxt_st.word_cnt_ff  = st_ff.word_cnt_ff + 16'h0_001;
    end

    // Serial bit and forwarded clock halves, aligned to each other
    nxt_st.ser_bit_ff = nxt_st.shift_vld_ff ? nxt_st.shift_ff[9] : lvtx_pkg::IDLE_LEVEL;
    if (!nxt_st.shift_vld_ff || !st_ff.cfg_ff.fwd_en) begin
      nxt_st.fwd_a_ff = lvtx_pkg::IDLE_LEVEL;
      nxt_st.fwd_b_ff = lvtx_pkg::IDLE_LEVEL;
    end else if (st_ff.cfg_ff.mode != lvtx_pkg::MODE_SER) begin
      nxt_st.fwd_a_ff = !st_ff.cfg_ff.phase_180;
      nxt_st.fwd_b_ff = st_ff.cfg_ff.phase_180;
    end else begin
      // High for the first half of the divided period, or for the second half at 180 degrees
      nxt_st.fwd_a_ff = ({1'b0, nxt_st.fwd_cnt_ff, 1'b0} < {2'b00, st_ff.cfg_ff.fwd_div})
                        ^ st_ff.cfg_ff.phase_180;
      nxt_st.fwd_b_ff = ({1'b0, nxt_st.fwd_cnt_ff, 1'b1} < {2'b00, st_ff.cfg_ff.fwd_div})
                        ^ st_ff.cfg_ff.phase_180;
    end

    // Register writes take effect in the access phase
    if (wr_en) begin
      case (PADDR)
        lvtx_pkg::OFS_CTRL: begin
          nxt_st.cfg_ff.enable    = PWDATA[lvtx_pkg::CTRL_EN_BIT];
          if (PWDATA[lvtx_pkg::CTRL_MODE_LSB +: 2] != 2'b11) begin
            nxt_st.cfg_ff.mode = lvtx_pkg::lvtx_mode_t'(PWDATA[lvtx_pkg::CTRL_MODE_LSB +: 2]);
          end
          nxt_st.cfg_ff.clk_chan  = PWDATA[lvtx_pkg::CTRL_CLKCH_BIT];
          nxt_st.cfg_ff.fwd_en    = PWDATA[lvtx_pkg::CTRL_FWDEN_BIT];
          nxt_st.cfg_ff.phase_180 = PWDATA[lvtx_pkg::CTRL_PHASE_BIT];
        end
        lvtx_pkg::OFS_FACTOR: begin
          if (legal_factor(PWDATA[3:0])) begin
            nxt_st.cfg_ff.factor = PWDATA[3:0];
            nxt_st.bit_cnt_ff    = '0;
            nxt_st.par_vld_ff    = 1'b0;
            nxt_st.shift_vld_ff  = 1'b0;
            if (!legal_div(PWDATA[3:0], st_ff.cfg_ff.fwd_div)) begin
              nxt_st.cfg_ff.fwd_div = lvtx_pkg::RST_FWDDIV;
            end
          end
        end
        lvtx_pkg::OFS_FWDDIV: begin
          if (legal_div(st_ff.cfg_ff.factor, PWDATA[3:0])) begin
            nxt_st.cfg_ff.fwd_div = PWDATA[3:0];
          end
        end
        lvtx_pkg::OFS_PREEMPH: begin
          if (PWDATA[lvtx_pkg::PRE_VARIANT_BIT] != st_ff.cfg_ff.pre_variant) begin
            // Variant change returns the level to that variant's default
            nxt_st.cfg_ff.pre_variant = PWDATA[lvtx_pkg::PRE_VARIANT_BIT];
            nxt_st.cfg_ff.pre_level   = PWDATA[lvtx_pkg::PRE_VARIANT_BIT]
                                      ? lvtx_pkg::RST_PRE_VAR1 : lvtx_pkg::RST_PRE_VAR0;
          end else if (st_ff.cfg_ff.pre_variant ||
                       PWDATA[lvtx_pkg::PRE_LVL_LSB +: 2] <= lvtx_pkg::PRE_MAX_VAR0) begin
            nxt_st.cfg_ff.pre_level = PWDATA[lvtx_pkg::PRE_LVL_LSB +: 2];
          end
        end
        default: nxt_st.cfg_ff.enable = st_ff.cfg_ff.enable;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_ff                    <= '0;
      st_ff.cfg_ff.mode        <= lvtx_pkg::MODE_SER;
      st_ff.cfg_ff.factor      <= lvtx_pkg::RST_FACTOR;
      st_ff.cfg_ff.fwd_div     <= lvtx_pkg::RST_FWDDIV;
      st_ff.cfg_ff.pre_level   <= lvtx_pkg::RST_PRE_VAR0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Output element inputs per mode
  always_comb begin
    case (st_ff.cfg_ff.mode)
      lvtx_pkg::MODE_DDR: data_pair = '{first: TX_WORD[1], second: TX_WORD[0]};
      lvtx_pkg::MODE_SDR: data_pair = '{first: TX_WORD[0], second: TX_WORD[0]};
      default:            data_pair = '{first: st_ff.ser_bit_ff, second: st_ff.ser_bit_ff};
    endcase
    if (!st_ff.cfg_ff.enable) begin
      data_pair = '{first: lvtx_pkg::IDLE_LEVEL, second: lvtx_pkg::IDLE_LEVEL};
    end
    fwd_pair = '{first: st_ff.fwd_a_ff, second: st_ff.fwd_b_ff};
  end

  // Data channel output element
  lvtx_out_elem u_data_oe (
    .clk        (CLK),
    .rst_n      (rst_n),
    .mode       (st_ff.cfg_ff.mode),
    .din        (data_pair),
    .out_first  (TX_OUT_FIRST),
    .out_second (TX_OUT_SECOND)
  );

  // Forwarded clock output element, always registered to stay aligned
  lvtx_out_elem u_fwd_oe (
    .clk        (CLK),
    .rst_n      (rst_n),
    .mode       (lvtx_pkg::MODE_DDR),
    .din        (fwd_pair),
    .out_first  (TX_FWD_FIRST),
    .out_second (TX_FWD_SECOND)
  );

  assign TX_PREEMPH = st_ff.cfg_ff.pre_level;

endmodule

/* File: verification/lvtx_properties.sv */
// Checker for the serial transmitter: load spacing, idle level, bypass data, pre-emphasis.
// Assumes it is bound to the transmitter top and sees only that module's ports.
`timescale 1ns/1ps
module lvtx_properties (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [9:0]  TX_WORD,
  input wire logic        TX_LOAD,
  input wire logic        TX_OUT_FIRST,
  input wire logic        TX_OUT_SECOND,
  input wire logic        TX_FWD_FIRST,
  input wire logic        TX_FWD_SECOND,
  input wire logic [1:0]  TX_PREEMPH
);
  logic seen_load_ff;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  // Remembers whether any word has been taken since reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      seen_load_ff <= 1'b0;
    end else if (TX_LOAD) begin
      seen_load_ff <= 1'b1;
    end
  end

  // Isolated load pulse marks serial operation
  sequence ser_pulse;
    !TX_LOAD ##1 TX_LOAD ##1 !TX_LOAD;
  endsequence

  AST_READY_CONST: assert property (PREADY)
    else $error("ready dropped");
  AST_SLVERR_PHASE: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error flag outside access phase");
  AST_LOAD_GAP: assert property (ser_pulse |=> !TX_LOAD [*2])
    else $error("serial loads closer than four cycles");
  AST_SER_HALVES: assert property (ser_pulse |-> TX_OUT_FIRST == TX_OUT_SECOND)
    else $error("serial halves differ");
  AST_IDLE: assert property (!seen_load_ff && !TX_LOAD |-> !TX_OUT_FIRST && !TX_OUT_SECOND)
    else $error("output not idle before first word");
  AST_PRE_STATIC: assert property ($changed(TX_PREEMPH) |->
      $past(PSEL && PENABLE && PWRITE && PADDR == lvtx_pkg::OFS_PREEMPH))
    else $error("pre-emphasis changed without a write");
  AST_BYPASS_DATA: assert property (TX_LOAD [*3] |-> (TX_OUT_FIRST == TX_WORD[0]) ||
      (TX_OUT_FIRST == $past(TX_WORD[1]) && TX_OUT_SECOND == $past(TX_WORD[0])))
    else $error("bypass output does not follow word");
  AST_FWD_BYPASS: assert property (TX_LOAD [*3] |->
      (TX_FWD_FIRST != TX_FWD_SECOND) || !(TX_FWD_FIRST || TX_FWD_SECOND))
    else $error("forwarded clock halves wrong in bypass");

  // Main scenarios reached
  COV_SER: cover property (ser_pulse);
  COV_BYP: cover property (TX_LOAD [*3]);
  COV_ERR: cover property (PSLVERR);
  COV_PRE: cover property ($changed(TX_PREEMPH));
endmodule

/* File: verification/lvtx_rx_model.sv */
// Far-end receiver model: samples the serial line once per bit clock.
// Assumes one bit per rising edge of the bit clock shared with the sender.
`timescale 1ns/1ps
module lvtx_rx_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       din,
  output logic      [9:0] word
);
  // Newest bit enters at the bottom, so the first bit sent ends on top
  // Plain flops only, as a soft deserializer in general logic would be
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word <= 10'h000;
    end else begin
      word <= {word[8:0], din};
    end
  end
endmodule

/* File: verification/tb_top.sv */
// Testbench for the serial transmitter: APB setup, serial rows, bypass and reset cases.
// Assumes the design package is compiled first and the checker is bound below.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [3:0]  f;
    logic [31:0] ctrl;
    logic [9:0]  w;
    logic [9:0]  exp;
  } lvtx_row_t;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, tx_load, o1, o2, f1, f2, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  tx_word, rx_word;
  logic [1:0]  pre;
  logic [3:0]  s;
  int          err_count = 0;
  int          total_checks = 0;
  int          n;
  // Factor, control, word with junk above the factor, expected received bits
  lvtx_row_t   rows [7] = '{
    '{4'h4, 32'h0000_0001, 10'h3F9, 10'h009},
    '{4'h6, 32'h0000_0001, 10'h3ED, 10'h02D},
    '{4'h7, 32'h0000_0001, 10'h3DA, 10'h05A},
    '{4'h8, 32'h0000_0001, 10'h3B1, 10'h0B1},
    '{4'hA, 32'h0000_0001, 10'h2C5, 10'h2C5},
    '{4'h4, 32'h0000_0009, 10'h000, 10'h00C},
    '{4'hA, 32'h0000_0009, 10'h000, 10'h3E0}};

  lvtx_top u_lvtx_top (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_WORD(tx_word), .TX_LOAD(tx_load), .TX_OUT_FIRST(o1), .TX_OUT_SECOND(o2),
    .TX_FWD_FIRST(f1), .TX_FWD_SECOND(f2), .TX_PREEMPH(pre));
  lvtx_rx_model u_lvtx_rx_model (.clk(clk), .rst_n(nrst), .din(o1), .word(rx_word));

  // Bit clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, tx_word} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'({o1, o2, f1, f2}), 32'h0000_0000);
    chk(32'(pre), 32'h0000_0001);
    apb(1'b1, lvtx_pkg::OFS_FACTOR, 32'h0000_0005);
    apb(1'b0, lvtx_pkg::OFS_FACTOR, 32'h0000_0000);
    chk(rd, 32'h0000_000A);
    foreach (rows[i]) begin
      apb(1'b1, lvtx_pkg::OFS_CTRL, 32'h0000_0000);
      apb(1'b1, lvtx_pkg::OFS_FACTOR, 32'(rows[i].f));
      tx_word <= rows[i].w;
      apb(1'b1, lvtx_pkg::OFS_CTRL, rows[i].ctrl);
      apb(1'b0, lvtx_pkg::OFS_STATUS, 32'h0000_0000);
      chk(32'(rd[11:8]), 32'(rows[i].f));
      n = 0;
      do @(negedge clk); while (tx_load !== 1'b1 && ++n < 20);
      n = 0;
      do begin @(negedge clk); n++; end while (tx_load !== 1'b1 && n < 20);
      chk(32'(n), 32'(rows[i].f));
      // Last bit of the first word is sampled three rising edges after the next load strobe
      repeat (3) @(negedge clk);
      chk(32'(rx_word & (10'h3FF >> (10 - rows[i].f))), 32'(rows[i].exp));
      @(posedge clk);
    end
    apb(1'b1, lvtx_pkg::OFS_FWDDIV, 32'h0000_0004);
    apb(1'b0, lvtx_pkg::OFS_FWDDIV, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b1, lvtx_pkg::OFS_FWDDIV, 32'h0000_0002);
    apb(1'b1, lvtx_pkg::OFS_CTRL, 32'h0000_0011);
    repeat (25) @(negedge clk);
    s[3:2] = {f1, f2};
    @(negedge clk);
    s[1:0] = {f1, f2};
    chk(32'(s == 4'hC || s == 4'h3), 32'h0000_0001);
    apb(1'b1, lvtx_pkg::OFS_PREEMPH, 32'h0000_0003);
    chk(32'(pre), 32'h0000_0001);
    apb(1'b1, lvtx_pkg::OFS_PREEMPH, 32'h0000_0010);
    chk(32'(pre), 32'h0000_0000);
    apb(1'b1, lvtx_pkg::OFS_PREEMPH, 32'h0000_0013);
    chk(32'(pre), 32'h0000_0003);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
    apb(1'b1, lvtx_pkg::OFS_CTRL, 32'h0000_0000);
    tx_word <= 10'h002;
    apb(1'b1, lvtx_pkg::OFS_CTRL, 32'h0000_0013);
    repeat (3) @(negedge clk);
    chk(32'({o1, o2, f1, f2}), 32'h0000_000A);
    @(posedge clk);
    // 180-degree forwarded clock swaps the two halves
    apb(1'b1, lvtx_pkg::OFS_CTRL, 32'h0000_0033);
    repeat (3) @(negedge clk);
    chk(32'({o1, o2, f1, f2}), 32'h0000_0009);
    @(posedge clk);
    apb(1'b1, lvtx_pkg::OFS_CTRL, 32'h0000_0000);
    apb(1'b1, lvtx_pkg::OFS_CTRL, 32'h0000_0005);
    for (int b = 0; b < 4; b++) begin
      tx_word <= 10'(b % 2);
      @(negedge clk);
      chk(32'(o1), 32'(b % 2));
      @(posedge clk);
    end
    nrst <= 1'b0;
    @(negedge clk);
    chk(32'({o1, o2, f1, f2, pre}), 32'h0000_0001);
    wrap_up();
  end
endmodule

bind lvtx_top lvtx_properties u_lvtx_properties (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PREADY, .PSLVERR, .TX_WORD, .TX_LOAD, .TX_OUT_FIRST, .TX_OUT_SECOND, .TX_FWD_FIRST,
  .TX_FWD_SECOND, .TX_PREEMPH);
